/* File: pkg/wit_pkg.sv */
// constants for the watchdog and interval timer
package wit_pkg;
    // register addresses on the cpu bus
    localparam logic [15:0] WIT_ADDR_WRITE     = 16'hffa8;
    localparam logic [15:0] WIT_ADDR_CTRL_RD   = 16'hffa8;
    localparam logic [15:0] WIT_ADDR_COUNT_RD  = 16'hffa9;
    // upper-byte keys that pick the target of a word write
    localparam logic [7:0]  WIT_KEY_COUNT      = 8'h5a;
    localparam logic [7:0]  WIT_KEY_CTRL       = 8'ha5;
    // control_status field positions
    localparam int unsigned WIT_BIT_OVF        = 7;
    localparam int unsigned WIT_BIT_MODE       = 6;
    localparam int unsigned WIT_BIT_ENABLE     = 5;
    localparam int unsigned WIT_BIT_PSRC       = 4;
    localparam int unsigned WIT_BIT_ACTION     = 3;
    localparam int unsigned WIT_CKS_LSB        = 0;
    localparam int unsigned WIT_CKS_WIDTH      = 3;
    // reset values
    localparam logic [7:0]  WIT_CTRL_RESET     = 8'h00;
    localparam logic [7:0]  WIT_COUNT_RESET    = 8'h00;
    // counter width and internal reset length in system clocks
    localparam int unsigned WIT_CNT_WIDTH      = 8;
    localparam int unsigned WIT_RESET_CYCLES   = 518;
    // prescaler widths: system clock up to /131072, sub clock up to /256
    localparam int unsigned WIT_PSM_WIDTH      = 17;
    localparam int unsigned WIT_PSS_WIDTH      = 8;
endpackage : wit_pkg

/* File: rtl/wit_top.sv */
// watchdog / interval timer with keyed word writes and byte reads
//
// Contract
// R1: interval mode overflow flag raises interval_irq
// R2: software clears overflow_flag in its handler
// R3: watchdog nmi option: overflow requests nmi
// R4: only word writes update count or control
// R5: key 5a in upper byte loads count; while the timer is stopped the code keeps count at zero instead
// R6: key a5 loads control; other keys ignored
// R7: control reads at ffa8, count at ffa9
// R8: write in same cycle beats count tick
// R9: stop timer before changing clock select
// R10: stop timer before changing prescaler source
// R11: stop timer before switching timer mode
// R12: enable starts counting; clearing zeroes count
// R13: mode bit zero interval, one watchdog
// R14: watchdog overflow: nmi, or 518-clock reset
// R15: 8-bit counter wraps, overflow one tick
`timescale 1ns/1ps
module wit_top #(
    parameter int unsigned CNT_WIDTH  = wit_pkg::WIT_CNT_WIDTH,
    parameter int unsigned RST_CYCLES = wit_pkg::WIT_RESET_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        sub_clock_pin,
    input  wire logic        bus_write,
    input  wire logic        bus_read,
    input  wire logic        bus_word,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output logic      [7:0]  bus_rdata,
    output logic             interval_irq,
    output logic             nmi_req,
    output logic             internal_reset
);
    import wit_pkg::*;

    localparam int unsigned RW = (RST_CYCLES < 2) ? 1 : $clog2(RST_CYCLES + 1);

    // refuse widths the byte-wide register path cannot carry;
    // checked while elaborating, so a bad build never reaches simulation
    if (CNT_WIDTH < 1 || CNT_WIDTH > 8) begin : g_bad_width
        $error("wit_top: CNT_WIDTH must be 1 to 8");
    end
    // a zero-length internal reset would never be seen by the system
    if (RST_CYCLES < 1) begin : g_bad_reset
        $error("wit_top: RST_CYCLES must be at least 1");
    end

    // tick when the low bits of the selected prescaler are all ones
    function automatic logic psm_tick(input logic [WIT_PSM_WIDTH-1:0] cnt,
                                      input logic [2:0] sel);
        logic [WIT_PSM_WIDTH-1:0] m;
        m = '0;
        unique case (sel)
            3'h0: m = 17'h00001;
            3'h1: m = 17'h0003f;
            3'h2: m = 17'h0007f;
            3'h3: m = 17'h001ff;
            3'h4: m = 17'h007ff;
            3'h5: m = 17'h01fff;
            3'h6: m = 17'h07fff;
            3'h7: m = 17'h1ffff;
        endcase
        return (cnt & m) == m;
    endfunction : psm_tick

    // sub prescaler divides by 2 to 256, one power of two per code
    function automatic logic pss_tick(input logic [WIT_PSS_WIDTH-1:0] cnt,
                                      input logic [2:0] sel);
        logic [WIT_PSS_WIDTH-1:0] m;
        m = 8'((9'h002 << sel) - 9'h001);
        return (cnt & m) == m;
    endfunction : pss_tick

    // state
    logic                     sub_s1_r, sub_s2_r, sub_s3_r;
    logic [WIT_PSM_WIDTH-1:0] psm_r, psm_nxt;
    logic [WIT_PSS_WIDTH-1:0] pss_r, pss_nxt;
    logic [CNT_WIDTH-1:0]     count_r, count_nxt;
    logic                     ovf_r, ovf_nxt;
    logic                     mode_r, mode_nxt;
    logic                     en_r, en_nxt;
    logic                     psrc_r, psrc_nxt;
    logic                     act_r, act_nxt;
    logic [2:0]               cks_r, cks_nxt;
    logic [RW-1:0]            rst_cnt_r, rst_cnt_nxt;
    logic [7:0]               rdata_r, rdata_nxt;
    logic                     irq_r, irq_nxt;
    logic                     nmi_r, nmi_nxt;
    logic                     irst_r, irst_nxt;

    // write decode and count tick
    logic       wr_ok;
    logic       cnt_wr;
    logic       ctl_wr;
    logic       sub_edge;
    logic       tick;
    logic       overflow;
    logic [7:0] ctrl_view;

    // byte writes never reach either register
    assign wr_ok    = bus_write && bus_word && (bus_addr == WIT_ADDR_WRITE);    // R4
    assign cnt_wr   = wr_ok && (bus_wdata[15:8] == WIT_KEY_COUNT);             // R5
    assign ctl_wr   = wr_ok && (bus_wdata[15:8] == WIT_KEY_CTRL);              // R6
    assign sub_edge = sub_s2_r && !sub_s3_r;
    assign tick     = psrc_r ? (sub_edge && pss_tick(pss_r, cks_r))
                             : psm_tick(psm_r, cks_r);
    // a keyed count write swallows the tick of the same cycle
    assign overflow = en_r && tick && !cnt_wr && (&count_r);                   // R8 R15
    assign ctrl_view = {ovf_r, mode_r, en_r, psrc_r, act_r, cks_r};

    // prescalers run free; changing source or divider mid-count is a
    // software hazard, so no resynchronisation is attempted here
    always_comb begin
        psm_nxt = psm_r + 1'b1;
        pss_nxt = sub_edge ? pss_r + 1'b1 : pss_r;
    end

    // control_status and count next values
    always_comb begin
        mode_nxt  = mode_r;
        en_nxt    = en_r;
        psrc_nxt  = psrc_r;
        act_nxt   = act_r;
        cks_nxt   = cks_r;
        ovf_nxt   = ovf_r;
        count_nxt = count_r;
        if (ctl_wr) begin
            mode_nxt = bus_wdata[WIT_BIT_MODE];                                // R11 R13
            en_nxt   = bus_wdata[WIT_BIT_ENABLE];
            psrc_nxt = bus_wdata[WIT_BIT_PSRC];                                // R10
            act_nxt  = bus_wdata[WIT_BIT_ACTION];
            cks_nxt  = bus_wdata[WIT_CKS_LSB +: WIT_CKS_WIDTH];                // R9
            // flag takes only a zero, and only to clear it
            if (!bus_wdata[WIT_BIT_OVF]) begin
                ovf_nxt = 1'b0;                                                // R2
            end
        end
        // a fresh overflow beats a clear in the same cycle
        if (overflow) begin
            ovf_nxt = 1'b1;                                                    // R1
        end
        if (cnt_wr) begin
            count_nxt = bus_wdata[CNT_WIDTH-1:0];                              // R5 R8
        end else if (en_r && tick) begin
            count_nxt = count_r + 1'b1;                                        // R12 R15
        end
        // a stopped timer holds zero, even against a keyed count write
        if (!en_nxt) begin
            count_nxt = '0;                                                    // R12
        end
    end

    // overflow actions and read data
    always_comb begin
        irq_nxt     = ovf_nxt && !mode_nxt;                                    // R1 R13
        nmi_nxt     = overflow && mode_r && !act_r;                            // R3 R14
        rst_cnt_nxt = rst_cnt_r;
        irst_nxt    = irst_r;
        if (overflow && mode_r && act_r) begin
            rst_cnt_nxt = RW'(RST_CYCLES);                                     // R14
            irst_nxt    = 1'b1;
        end else if (rst_cnt_r != '0) begin
            rst_cnt_nxt = rst_cnt_r - 1'b1;
            irst_nxt    = (rst_cnt_r != RW'(1));
        end
        rdata_nxt = rdata_r;
        if (bus_read) begin
            if (bus_addr == WIT_ADDR_CTRL_RD) begin
                rdata_nxt = ctrl_view;                                         // R7
            end else if (bus_addr == WIT_ADDR_COUNT_RD) begin
                rdata_nxt = 8'(count_r);                                       // R7
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // all state, frozen while clk_en is low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sub_s1_r  <= 1'b0;
            sub_s2_r  <= 1'b0;
            sub_s3_r  <= 1'b0;
            psm_r     <= '0;
            pss_r     <= '0;
            count_r   <= CNT_WIDTH'(WIT_COUNT_RESET);
            ovf_r     <= WIT_CTRL_RESET[WIT_BIT_OVF];
            mode_r    <= WIT_CTRL_RESET[WIT_BIT_MODE];
            en_r      <= WIT_CTRL_RESET[WIT_BIT_ENABLE];
            psrc_r    <= WIT_CTRL_RESET[WIT_BIT_PSRC];
            act_r     <= WIT_CTRL_RESET[WIT_BIT_ACTION];
            cks_r     <= WIT_CTRL_RESET[WIT_CKS_LSB +: WIT_CKS_WIDTH];
            rst_cnt_r <= '0;
            rdata_r   <= 8'h00;
            irq_r     <= 1'b0;
            nmi_r     <= 1'b0;
            irst_r    <= 1'b0;
        end else if (clk_en) begin
            sub_s1_r  <= sub_clock_pin;
            sub_s2_r  <= sub_s1_r;
            sub_s3_r  <= sub_s2_r;
            psm_r     <= psm_nxt;
            pss_r     <= pss_nxt;
            count_r   <= count_nxt;
            ovf_r     <= ovf_nxt;
            mode_r    <= mode_nxt;
            en_r      <= en_nxt;
            psrc_r    <= psrc_nxt;
            act_r     <= act_nxt;
            cks_r     <= cks_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            rdata_r   <= rdata_nxt;
            irq_r     <= irq_nxt;
            nmi_r     <= nmi_nxt;
            irst_r    <= irst_nxt;
        end
    end

    assign bus_rdata      = rdata_r;
    assign interval_irq   = irq_r;
    assign nmi_req        = nmi_r;
    assign internal_reset = irst_r;
endmodule : wit_top

/* File: tb/wit_top_chk.sv */
// port checker for the watchdog and interval timer
`timescale 1ns/1ps
module wit_top_chk import wit_pkg::*; #(
    parameter int unsigned RST_CYCLES = WIT_RESET_CYCLES
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        bus_write,
    input wire logic        bus_read,
    input wire logic        bus_word,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic [7:0]  bus_rdata,
    input wire logic        interval_irq,
    input wire logic        nmi_req,
    input wire logic        internal_reset
);
    logic [15:0] len_r;
    logic [15:0] len_nxt;
    // length of the running internal reset pulse
    always_comb len_nxt = internal_reset ? len_r + 16'h1 : 16'h0;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) len_r <= 16'h0;
        else if (clk_en) len_r <= len_nxt;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_rdc; bus_read && bus_addr == WIT_ADDR_CTRL_RD; endsequence
    sequence s_gap; !(bus_read || bus_write); endsequence
    sequence s_wrc; bus_write && bus_word && bus_addr == WIT_ADDR_WRITE
        && bus_wdata[15:8] == WIT_KEY_CTRL; endsequence
    sequence s_bad; bus_write && !bus_read && bus_addr == WIT_ADDR_WRITE
        && !(bus_word && bus_wdata[15:8] == WIT_KEY_CTRL); endsequence
    // flag bit masked: an overflow may set it at any time
    property p_ctrl_wr; s_wrc ##1 s_gap ##1 s_rdc |=> bus_rdata[6:0] == $past(bus_wdata[6:0], 3);
    endproperty
    property p_no_wr; s_rdc ##1 s_gap ##1 s_bad ##1 s_gap ##1 s_rdc |=> $stable(bus_rdata[6:0]);
    endproperty
    property p_unmap; bus_read && bus_addr != WIT_ADDR_CTRL_RD && bus_addr != WIT_ADDR_COUNT_RD
        |=> bus_rdata == 8'h00; endproperty
    property p_hold; !bus_read |=> $stable(bus_rdata); endproperty
    property p_irq; interval_irq && bus_read && bus_addr == WIT_ADDR_CTRL_RD
        |=> bus_rdata[7:6] == 2'b10; endproperty
    property p_nmi; nmi_req |=> !nmi_req; endproperty
    property p_len; $fell(internal_reset) && len_r != 16'h0 |-> len_r == RST_CYCLES; endproperty
    property p_max; len_r <= RST_CYCLES; endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write not seen");
    a_no_wr: assert property (p_no_wr) else $error("control changed by bad write");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_irq: assert property (p_irq) else $error("irq without flag");
    a_nmi: assert property (p_nmi) else $error("nmi pulse too long");
    a_len: assert property (p_len) else $error("reset pulse length");
    a_max: assert property (p_max) else $error("reset pulse too long");
endmodule : wit_top_chk
bind wit_top wit_top_chk #(.RST_CYCLES(RST_CYCLES)) u_wit_top_chk (
    .clock(clock), .reset(reset), .clk_en(clk_en), .bus_write(bus_write),
    .bus_read(bus_read), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .interval_irq(interval_irq), .nmi_req(nmi_req),
    .internal_reset(internal_reset));

/* File: tb/wit_top_tb_top.sv */
// self-checking bench for the watchdog and interval timer
`timescale 1ns/1ps
module wit_top_tb_top;
    import wit_pkg::*;
    localparam int unsigned RST = 4; // short internal reset keeps the run brief
    localparam logic [15:0] CT  = WIT_ADDR_CTRL_RD;
    localparam logic [15:0] CN  = WIT_ADDR_COUNT_RD;
    logic        clock, reset, sub_clock_pin, bus_write, bus_read, bus_word;
    logic        interval_irq, nmi_req, internal_reset;
    logic [15:0] bus_addr, bus_wdata;
    logic [7:0]  bus_rdata;
    int          n_fail, n_checks, n;
    wit_top #(.RST_CYCLES(RST)) u_wit_top (
        .clock(clock), .reset(reset), .clk_en(1'b1), .sub_clock_pin(sub_clock_pin),
        .bus_write(bus_write), .bus_read(bus_read), .bus_word(bus_word),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .interval_irq(interval_irq), .nmi_req(nmi_req), .internal_reset(internal_reset));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one access from a falling edge, with an idle cycle after it
    task acc(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
        @(negedge clock);
        bus_write = w;
        bus_read  = !w;
        bus_word  = wd;
        bus_addr  = a;
        bus_wdata = d;
        @(negedge clock);
        bus_write = 1'b0;
        bus_read  = 1'b0;
    endtask : acc
    task wr(input logic [15:0] d, input logic wd = 1'b1);
        acc(1'b1, wd, CT, d);
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, a, 16'h0000);
        chk(bus_rdata, e);
    endtask : rd
    task t_regs;
        rd(CT, 8'h00);
        rd(CN, 8'h00);
        wr(16'ha507);
        rd(CT, 8'h07);
        wr(16'h3301);
        rd(CT, 8'h07);
        wr(16'ha502, 1'b0);
        rd(CT, 8'h07);
        wr(16'h5a10);
        rd(CN, 8'h00);
        rd(CT + 16'h2, 8'h00);
    endtask : t_regs
    task t_interval;
        wr(16'ha527);
        wr(16'h5afd);
        rd(CN, 8'hfd);
        wr(16'ha507);
        rd(CN, 8'h00);
        wr(16'ha520);
        wr(16'h5afe);
        repeat (20) if (!interval_irq) @(negedge clock);
        chk(interval_irq, 8'h01);
        rd(CT, 8'ha0);
        wr(16'ha520);
        chk(interval_irq, 8'h00);
        // hold a count write of ff over several ticks: a lost write would overflow
        @(negedge clock);
        bus_write = 1'b1;
        bus_wdata = 16'h5aff;
        repeat (6) @(negedge clock);
        bus_write = 1'b0;
        chk(interval_irq, 8'h00);
        wr(16'ha500);
    endtask : t_interval
    task t_watchdog;
        wr(16'ha540);
        wr(16'ha560);
        wr(16'h5afe);
        repeat (20) if (!nmi_req) @(negedge clock);
        chk(nmi_req, 8'h01);
        chk(interval_irq, 8'h00);
        wr(16'ha548);
        wr(16'ha568);
        wr(16'h5afe);
        repeat (20) if (!internal_reset) @(negedge clock);
        for (n = 0; internal_reset && n < 50; n++) @(negedge clock);
        chk(8'(n), 8'(RST));
        wr(16'ha540);
    endtask : t_watchdog
    // sub clock source: no tick without pin edges, then one per two edges
    task t_sub;
        wr(16'ha510);
        wr(16'ha530);
        wr(16'h5afe);
        repeat (20) @(negedge clock);
        rd(CN, 8'hfe);
        // six rising edges at divide-by-two: fe -> ff -> 00 -> 01
        repeat (6) begin
            sub_clock_pin = 1'b1;
            repeat (4) @(negedge clock);
            sub_clock_pin = 1'b0;
            repeat (4) @(negedge clock);
        end
        chk(interval_irq, 8'h01);
        rd(CN, 8'h01);
        rd(CT, 8'hb0);
        wr(16'ha510);
        chk(interval_irq, 8'h00);
    endtask : t_sub
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        {n_fail, n_checks, reset} = {32'd0, 32'd0, 1'b1};
        {bus_write, bus_read, bus_word, sub_clock_pin} = 4'h0;
        {bus_addr, bus_wdata} = 32'h0;
        repeat (12) @(negedge clock);
        reset = 1'b0;
        t_regs();
        t_interval();
        t_watchdog();
        t_sub();
        end_of_test();
    end
    // the scenarios need well under a thousand cycles
    initial begin
        #50us;
        n_fail++;
        end_of_test();
    end
endmodule : wit_top_tb_top
